// *** core/multi_speed_jog_select.sv ***
// Speed command selection: multi-speed table, jog and run decode.
// Assumes terminal pins are asynchronous; configuration and keypad
// signals come from logic on sys_clk.
//
// Contract
// - Hold sixteen target frequencies and pick one as the speed command.
// - Any select bit function may sit on any of six input terminals.
// - Select inputs form an unsigned index, bit zero least significant.
// - Function codes 02 to 05 assign select bits zero to three.
// - Index zero takes the normal frequency setting, not a table entry.
// - Select changes while running change the command immediately.
// - An edit is stored only on the store key.
// - In stop, display entry n; store writes entry n.
// - Jog frequency is capped at 9.99 Hz.
// - Jog with run outputs the jog frequency directly, no ramp.
// - Code 06 makes a jog input; inactive jog ends in stop.
// - Jog stop method 00 to 05; upper group ignores jog while running.
// - No jog when jog frequency is zero or below start frequency.
// - Run inputs command run; both active together command stop.
`timescale 1ns/1ps

module multi_speed_jog_select
    import speed_select_pkg::*;
(
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rst_n,
    // Terminals and their function codes
    input  wire logic [NUM_TERMS-1:0]            term_pin,
    input  wire logic [NUM_TERMS-1:0][7:0]       term_func,
    // Drive settings
    input  wire drive_cfg_type                   cfg,
    // Keypad edit and store
    input  wire logic [FREQ_W-1:0]               edit_value,
    input  wire logic                            store_key,
    // Speed command and status
    output logic [FREQ_W-1:0]                    freq_command,
    output logic [FREQ_W-1:0]                    display_value,
    output logic [SEL_BITS-1:0]                  speed_index,
    output logic                                 run_mode,
    output logic                                 reverse_dir,
    output logic                                 jog_active,
    output stop_kind_type                        jog_end
);

    // ------------------------------------------------------------
    // Pin synchroniser and function decode
    // ------------------------------------------------------------
    logic [NUM_TERMS-1:0]                 pin_meta;
    logic [NUM_TERMS-1:0]                 pin_sync;
    logic [NUM_TERMS-1:0][NUM_FUNCS-1:0]  hit;
    logic [SEL_BITS-1:0]                  next_index;
    logic                                 fw_hit;
    logic                                 rv_hit;
    logic                                 jog_hit;
    logic                                 run_fwd_q;
    logic                                 run_rev_q;
    logic                                 jog_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= term_pin;
            pin_sync <= pin_meta;
        end
    end

    for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
        for (genvar f = 0; f < NUM_FUNCS; f++) begin : g_func
            assign hit[t][f] = pin_sync[t] && (term_func[t] == 8'(f));
        end
    end

    always_comb begin
        next_index = '0;
        fw_hit     = 1'b0;
        rv_hit     = 1'b0;
        jog_hit    = 1'b0;
        for (int t = 0; t < NUM_TERMS; t++) begin
            fw_hit  = fw_hit | hit[t][int'(FUNC_FWD)];
            rv_hit  = rv_hit | hit[t][int'(FUNC_REV)];
            jog_hit = jog_hit | hit[t][int'(FUNC_JOG)];
            for (int k = 0; k < SEL_BITS; k++) begin
                next_index[k] = next_index[k] | hit[t][int'(FUNC_SEL_BASE) + k];
            end
        end
    end

    // Sampled terminal state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_index <= '0;
            run_fwd_q   <= 1'b0;
            run_rev_q   <= 1'b0;
            jog_q       <= 1'b0;
        end else begin
            speed_index <= next_index;
            run_fwd_q   <= fw_hit;
            run_rev_q   <= rv_hit;
            jog_q       <= jog_hit;
        end
    end

    // ------------------------------------------------------------
    // Speed table and selection
    // ------------------------------------------------------------
    logic [FREQ_W-1:0]     speed_table [NUM_SPEEDS];
    logic [FREQ_W-1:0]     selected;
    logic [FREQ_W-1:0]     selected_clamped;
    logic [FREQ_W-1:0]     jog_capped;
    drive_state_type       state;
    drive_state_type       next_state;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_SPEEDS; i++) begin
                speed_table[i] <= '0;
            end
        end else if (store_key && state == ST_STOP && speed_index != SPEED_ZERO) begin
            speed_table[speed_index] <= edit_value;
        end
    end

    always_comb begin
        if (speed_index == SPEED_ZERO) begin
            selected = cfg.freq_setting;
        end else begin
            selected = speed_table[speed_index];
        end
        if (selected > cfg.max_freq) begin
            selected_clamped = cfg.max_freq;
        end else begin
            selected_clamped = selected;
        end
        if (cfg.jog_freq > JOG_FREQ_CAP) begin
            jog_capped = JOG_FREQ_CAP;
        end else begin
            jog_capped = cfg.jog_freq;
        end
    end

    // ------------------------------------------------------------
    // Run and jog sequencing
    // ------------------------------------------------------------
    logic            run_cmd;
    logic            jog_ok;
    logic            accept_running;
    logic [7:0]      method_low;
    stop_kind_type   stop_kind;

    assign run_cmd        = run_fwd_q ^ run_rev_q;
    assign jog_ok         = (cfg.jog_freq != FREQ_ZERO)
                            && (cfg.jog_freq >= cfg.start_freq);
    assign accept_running = cfg.jog_stop_method < JOG_STOP_GROUP;

    always_comb begin
        if (cfg.jog_stop_method >= JOG_STOP_GROUP) begin
            method_low = cfg.jog_stop_method - JOG_STOP_GROUP;
        end else begin
            method_low = cfg.jog_stop_method;
        end
        stop_kind.coast    = method_low == JOG_STOP_COAST;
        stop_kind.dc_brake = method_low == JOG_STOP_DCBRK;
        stop_kind.decel    = !stop_kind.coast && !stop_kind.dc_brake;
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_STOP: begin
                if (run_cmd && jog_q && jog_ok) begin
                    next_state = ST_JOG;
                end else if (run_cmd) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!run_cmd) begin
                    next_state = ST_STOP;
                end else if (jog_q && jog_ok && accept_running) begin
                    next_state = ST_JOG;
                end
            end
            ST_JOG: begin
                if (!jog_q || !run_cmd) begin
                    next_state = ST_JOG_END;
                end
            end
            ST_JOG_END: begin
                next_state = ST_STOP;
            end
            default: begin
                next_state = ST_STOP;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_STOP;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_command <= '0;
        end else begin
            case (next_state)
                ST_RUN:  freq_command <= selected_clamped;
                ST_JOG:  freq_command <= jog_capped;
                default: freq_command <= '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            display_value <= '0;
        end else begin
            display_value <= selected;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_mode    <= 1'b0;
            reverse_dir <= 1'b0;
            jog_active  <= 1'b0;
            jog_end     <= '0;
        end else begin
            run_mode    <= (next_state == ST_RUN) || (next_state == ST_JOG);
            reverse_dir <= run_rev_q && !run_fwd_q;
            jog_active  <= next_state == ST_JOG;
            jog_end     <= (next_state == ST_JOG_END) ? stop_kind : '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_sel_bit_map: assert property (
        (pin_sync[0] && term_func[0] == FUNC_SEL_BASE) |=> speed_index[0])
        else $error("select bit zero not taken from code 02 terminal");

    a_speed_zero_src: assert property (
        (next_state == ST_RUN && speed_index == SPEED_ZERO
         && cfg.freq_setting <= cfg.max_freq) |=> freq_command == $past(cfg.freq_setting))
        else $error("speed zero not from frequency setting");

    a_table_used: assert property (
        (next_state == ST_RUN && speed_index != SPEED_ZERO
         && speed_table[speed_index] <= cfg.max_freq)
        |=> freq_command == $past(speed_table[speed_index]))
        else $error("running command not from table entry");

    a_store_commit: assert property (
        (store_key && state == ST_STOP && speed_index != SPEED_ZERO)
        |=> speed_table[$past(speed_index)] == $past(edit_value))
        else $error("store did not write selected entry");

    a_store_hold: assert property (
        !store_key
        |=> speed_table[$past(speed_index)] == $past(speed_table[speed_index]))
        else $error("entry changed without store");

    a_jog_cap: assert property (
        jog_active |-> freq_command <= JOG_FREQ_CAP)
        else $error("jog command above cap");

    a_jog_direct: assert property (
        state == ST_JOG |-> jog_active && freq_command == $past(jog_capped))
        else $error("jog frequency not output directly");

    a_jog_refused: assert property (
        (!jog_ok && state != ST_JOG) |=> state != ST_JOG)
        else $error("jog entered with invalid jog frequency");

    a_jog_ignored: assert property (
        (state == ST_RUN && !accept_running) |=> state != ST_JOG)
        else $error("jog accepted while running in upper group");

    a_both_stop: assert property (
        (run_fwd_q && run_rev_q) |=> !run_mode && !jog_active)
        else $error("both run inputs did not stop");

    a_jog_end_pulse: assert property (
        (state == ST_JOG && !jog_q) |=> $countones(jog_end) == 1 ##1 jog_end == '0)
        else $error("jog end not a single one-cycle stop pulse");

endmodule : multi_speed_jog_select

// *** core/speed_select_pkg.sv ***
// Constants, carriers and state codes for the speed select block.
// Assumes one 40 MHz drive clock; frequencies are in 0.01 Hz units.
package speed_select_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_TERMS  = 6;
    localparam int NUM_SPEEDS = 16;
    localparam int SEL_BITS   = 4;
    localparam int FREQ_W     = 16;
    localparam int NUM_FUNCS  = 7;

    // ------------------------------------------------------------
    // Terminal function codes
    // ------------------------------------------------------------
    localparam logic [7:0] FUNC_FWD      = 8'h00;
    localparam logic [7:0] FUNC_REV      = 8'h01;
    localparam logic [7:0] FUNC_SEL_BASE = 8'h02;
    localparam logic [7:0] FUNC_JOG      = 8'h06;

    // ------------------------------------------------------------
    // Jog limits and stop methods
    // ------------------------------------------------------------
    localparam logic [FREQ_W-1:0] JOG_FREQ_CAP   = 16'h03e7;
    localparam logic [FREQ_W-1:0] FREQ_ZERO      = 16'h0000;
    localparam logic [7:0]        JOG_STOP_GROUP = 8'h03;
    localparam logic [7:0]        JOG_STOP_COAST = 8'h00;
    localparam logic [7:0]        JOG_STOP_DECEL = 8'h01;
    localparam logic [7:0]        JOG_STOP_DCBRK = 8'h02;
    localparam logic [3:0]        SPEED_ZERO     = 4'h0;

    typedef struct packed {
        logic [FREQ_W-1:0] freq_setting;
        logic [FREQ_W-1:0] max_freq;
        logic [FREQ_W-1:0] start_freq;
        logic [FREQ_W-1:0] jog_freq;
        logic [7:0]        jog_stop_method;
    } drive_cfg_type;

    typedef struct packed {
        logic coast;
        logic decel;
        logic dc_brake;
    } stop_kind_type;

    typedef enum logic [3:0] {
        ST_STOP    = 4'b0001,
        ST_RUN     = 4'b0010,
        ST_JOG     = 4'b0100,
        ST_JOG_END = 4'b1000
    } drive_state_type;

endpackage : speed_select_pkg

// *** tb/terminal_switches.sv ***
// Far-side model: switches wired to the six intelligent input terminals.
// Assumes the bench changes requests at the falling edge; levels follow at once.
`timescale 1ns/1ps

module terminal_switches
    import speed_select_pkg::*;
(
    // Requested switch levels
    input  wire logic                      fwd,
    input  wire logic                      rev,
    input  wire logic                      jog,
    input  wire logic [3:0]                sel,
    // Wiring choices
    input  wire logic                      rev_mode,
    input  wire logic [2:0]                rot,
    // Terminals
    output logic [NUM_TERMS-1:0]           term_pin,
    output logic [NUM_TERMS-1:0][7:0]      term_func
);
    logic [5:0]      lvl;
    logic [5:0][7:0] code;

    // ------------------------------------------------------------
    // Wiring
    // ------------------------------------------------------------
    always_comb begin
        // Run and jog come from terminals only
        lvl  = {rev_mode ? rev : sel[3], sel[2], sel[1], sel[0], jog, fwd};
        code = {rev_mode ? FUNC_REV : 8'h05, 8'h04, 8'h03, FUNC_SEL_BASE, FUNC_JOG, FUNC_FWD};
        term_pin  = '0;
        term_func = '0;
        for (int i = 0; i < NUM_TERMS; i++) begin
            term_pin[(i + int'(rot)) % NUM_TERMS]  = lvl[i];
            term_func[(i + int'(rot)) % NUM_TERMS] = code[i];
        end
    end

endmodule : terminal_switches

// *** tb/test_multi_speed_jog_select.sv ***
// Self-checking bench for the speed select block.
// Assumes a 40 MHz clock and four edges from terminal change to command.
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module test_multi_speed_jog_select
    import speed_select_pkg::*;
;
    logic                         sys_clk     = 1'b0;
    logic                         rst_n       = 1'b0;
    logic                         fwd         = 1'b0;
    logic                         rev         = 1'b0;
    logic                         jog         = 1'b0;
    logic                         rev_mode    = 1'b0;
    logic [3:0]                   sel         = 4'h0;
    logic [2:0]                   rot         = 3'h0;
    logic [NUM_TERMS-1:0]         term_pin;
    logic [NUM_TERMS-1:0][7:0]    term_func;
    drive_cfg_type                cfg;
    logic [FREQ_W-1:0]            edit_value  = 16'h0000;
    logic                         store_key   = 1'b0;
    logic [FREQ_W-1:0]            freq_command;
    logic [FREQ_W-1:0]            display_value;
    logic [SEL_BITS-1:0]          speed_index;
    logic                         run_mode;
    logic                         reverse_dir;
    logic                         jog_active;
    stop_kind_type                jog_end;
    logic [FREQ_W-1:0]            tab [NUM_SPEEDS];
    int                           cyc         = 0;
    int                           n_errors    = 0;
    int                           comparisons = 0;
    int                           seed        = 90;
    int                           due_q [$];
    logic [41:0]                  exp_q [$];
    logic [41:0]                  seen;

    assign seen = {speed_index, run_mode, reverse_dir, jog_active, jog_end,
                   freq_command, display_value};

    multi_speed_jog_select multi_speed_jog_select_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .term_pin(term_pin), .term_func(term_func),
        .cfg(cfg), .edit_value(edit_value), .store_key(store_key),
        .freq_command(freq_command), .display_value(display_value),
        .speed_index(speed_index), .run_mode(run_mode), .reverse_dir(reverse_dir),
        .jog_active(jog_active), .jog_end(jog_end)
    );

    terminal_switches terminal_switches_inst (
        .fwd(fwd), .rev(rev), .jog(jog), .sel(sel), .rev_mode(rev_mode), .rot(rot),
        .term_pin(term_pin), .term_func(term_func)
    );

    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lim(input logic [15:0] a, input logic [15:0] b);
        return (a > b) ? b : a;
    endfunction : lim

    function automatic logic [2:0] jend(input int m);
        return 3'b100 >> (m % 3);
    endfunction : jend

    task automatic drive(input logic f, input logic r, input logic j, input logic [3:0] s,
                         input logic ej, input logic [2:0] ejend);
        logic        run;
        logic [15:0] fq;
        logic [15:0] disp;
        fwd = f;
        rev = r;
        jog = j;
        sel = s;
        run  = f ^ r;
        disp = (s == 4'h0) ? cfg.freq_setting : tab[s];
        fq   = ej ? lim(cfg.jog_freq, JOG_FREQ_CAP) : (run ? lim(disp, cfg.max_freq) : FREQ_ZERO);
        due_q.push_back(cyc + 4);
        exp_q.push_back({s, run, r & !f, ej, ejend, fq, disp});
        repeat (6) @(negedge sys_clk);
    endtask : drive

    task automatic store(input logic [15:0] v, input logic keep);
        edit_value = v;
        store_key  = 1'b1;
        @(negedge sys_clk);
        store_key  = 1'b0;
        if (keep) tab[sel] = v;
        edit_value = v ^ 16'h0f0f;
        @(negedge sys_clk);
    endtask : store

    task automatic wrap_up();
        $display("Errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Output monitor
    // ------------------------------------------------------------
    always @(negedge sys_clk) begin
        if (due_q.size() > 0 && due_q[0] == cyc) begin
            `CHECK(seen, exp_q[0])
            void'(due_q.pop_front());
            void'(exp_q.pop_front());
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        cfg = {16'h04d2, 16'h2000, 16'h00c8, 16'h00c8, 8'h00};
        for (int i = 0; i < NUM_SPEEDS; i++) tab[i] = 16'h0000;
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        rot = 3'($unsigned($random(seed)) % 6);
        for (int n = 0; n < NUM_SPEEDS; n++) begin
            drive(1'b0, 1'b0, 1'b0, 4'(n), 1'b0, 3'h0);
            store(16'($random(seed)) & 16'h1fff, n != 0);
            drive(1'b0, 1'b0, 1'b0, 4'(n), 1'b0, 3'h0);
        end
        drive(1'b1, 1'b0, 1'b0, 4'h5, 1'b0, 3'h0);
        store(16'h0abc, 1'b0);
        drive(1'b1, 1'b0, 1'b0, 4'h5, 1'b0, 3'h0);
        for (int b = 0; b < 4; b++) drive(1'b1, 1'b0, 1'b0, 4'(1 << b), 1'b0, 3'h0);
        repeat (20) drive(1'b1, 1'b0, 1'b0, 4'($random(seed)), 1'b0, 3'h0);
        drive(1'b0, 1'b0, 1'b0, 4'h0, 1'b0, 3'h0);
        rev_mode = 1'b1;
        drive(1'b0, 1'b1, 1'b0, 4'h3, 1'b0, 3'h0);
        drive(1'b1, 1'b1, 1'b0, 4'h3, 1'b0, 3'h0);
        drive(1'b0, 1'b0, 1'b0, 4'h0, 1'b0, 3'h0);
        rev_mode = 1'b0;
        for (int m = 0; m < 6; m++) begin
            cfg.jog_stop_method = 8'(m);
            cfg.jog_freq = m[0] ? 16'h05dc : 16'h00c8;
            drive(1'b1, 1'b0, 1'b1, 4'h2, 1'b1, 3'h0);
            drive(1'b0, 1'b0, 1'b0, 4'h2, 1'b0, jend(m));
            drive(1'b1, 1'b0, 1'b0, 4'h2, 1'b0, 3'h0);
            drive(1'b1, 1'b0, 1'b1, 4'h2, m < 3, 3'h0);
            drive(1'b0, 1'b0, 1'b0, 4'h2, 1'b0, (m < 3) ? jend(m) : 3'h0);
        end
        cfg.jog_freq = 16'h0000;
        drive(1'b1, 1'b0, 1'b1, 4'h6, 1'b0, 3'h0);
        drive(1'b0, 1'b0, 1'b0, 4'h6, 1'b0, 3'h0);
        cfg.jog_freq = 16'h0064;
        drive(1'b1, 1'b0, 1'b1, 4'h6, 1'b0, 3'h0);
        drive(1'b0, 1'b0, 1'b0, 4'h6, 1'b0, 3'h0);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end

endmodule : test_multi_speed_jog_select
